// ==== verilog/mbrrw_pkg.sv ====
// mbrrw_pkg: constants and carrier types of the register remap window
package mbrrw_pkg;

	// ----------------------------------------------------------------
	// window geometry
	// ----------------------------------------------------------------
	localparam logic [15:0] WIN_BASE    = 16'h1389; // first window register, 5001
	localparam int unsigned WIN_ENTRIES = 50;       // entries 5001..5050
	localparam logic [15:0] NULL_TARGET = 16'h0000; // target meaning "not remapped"
	localparam logic [15:0] NULL_RDATA  = 16'h0000; // read answer of a null entry
	localparam logic [5:0]  BOOT_SUP_EN = 6'h32;    // boot record after the table: timer enable

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 40000000;
	localparam int unsigned SUP_TIMEOUT_MS  = 1000; // gap allowed between connections
	localparam int unsigned CONN_TIMEOUT_MS = 1000; // idle allowed inside a connection
	localparam int unsigned SUP_TIMEOUT_CYC  = SUP_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned CONN_TIMEOUT_CYC = CONN_TIMEOUT_MS * (CLK_HZ / 1000);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        write;
		logic [15:0] addr;
		logic [15:0] wdata;
	} mbrrw_acc_s;

	typedef enum logic [1:0] {
		ST_BOOT  = 2'b00,
		ST_IDLE  = 2'b01,
		ST_LOOK  = 2'b10,
		ST_DRIVE = 2'b11
	} mbrrw_state_e;

endpackage

// ==== verilog/mbrrw_remap_mem.sv ====
// mbrrw_remap_mem: remap target table with registered read data
`timescale 1ns/1ps
`default_nettype none

module mbrrw_remap_mem #(
	parameter int unsigned DEPTH = 50,
	parameter int unsigned WIDTH = 16,
	parameter int unsigned AW    = 6
) (
	// clock, reset, enable
	input  wire logic             clk,
	input  wire logic             resetn,
	input  wire logic             ce,
	// write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_idx,
	input  wire logic [WIDTH-1:0] wr_data,
	// read port
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_idx,
	output logic      [WIDTH-1:0] rd_data_q
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [WIDTH-1:0] rd_data_d;

	initial begin
		if (DEPTH > (1 << AW)) $error("mbrrw_remap_mem: DEPTH does not fit AW");
	end

	// read path: hold the last word unless a new read is asked for
	always_comb begin
		rd_data_d = rd_data_q;
		if (rd_en) begin
			rd_data_d = mem[rd_idx];
		end
	end

	// array has no reset: contents only matter after the boot load
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data_q <= '0;
		end else if (ce) begin
			rd_data_q <= rd_data_d;
		end
	end

endmodule

`default_nettype wire

// ==== verilog/mbrrw_remap_window.sv ====
// mbrrw_remap_window: remap window, boot-time config load and connection timers
`timescale 1ns/1ps
`default_nettype none

module mbrrw_remap_window #(
	parameter int unsigned N_ENTRIES  = mbrrw_pkg::WIN_ENTRIES,
	parameter int unsigned SUP_CYCLES  = mbrrw_pkg::SUP_TIMEOUT_CYC,
	parameter int unsigned CONN_CYCLES = mbrrw_pkg::CONN_TIMEOUT_CYC
) (
	// clock, reset, enable
	input  wire logic                  clk,
	input  wire logic                  resetn,
	input  wire logic                  ce,
	// boot load from nonvolatile storage
	output logic                       nv_req_q,
	output logic      [5:0]            nv_addr_q,
	input  wire logic                  nv_valid,
	input  wire logic [15:0]           nv_data,
	input  wire logic                  commit,
	output logic                       reboot_req_q,
	// client register accesses, one word each
	input  wire logic                  req_valid,
	input  wire mbrrw_pkg::mbrrw_acc_s req,
	output logic                       req_ready_q,
	output logic                       rsp_valid_q,
	output logic      [15:0]           rsp_rdata_q,
	// drive register port
	output logic                       drv_valid_q,
	output mbrrw_pkg::mbrrw_acc_s      drv_q,
	input  wire logic                  drv_done,
	input  wire logic [15:0]           drv_rdata,
	// connection events and timeouts
	input  wire logic                  conn_open,
	input  wire logic                  conn_close,
	output logic                       sup_timeout_q,
	output logic                       conn_timeout_q
);

	// ----------------------------------------------------------------
	// checks and helpers
	// ----------------------------------------------------------------
	initial begin
		if (N_ENTRIES < 1 || N_ENTRIES > 50) $error("N_ENTRIES must be 1..50");
		if (SUP_CYCLES < 1 || CONN_CYCLES < 1) $error("timer counts must be nonzero");
	end

	function automatic logic in_window(input logic [15:0] a);
		return (a >= mbrrw_pkg::WIN_BASE) &&
			(a < mbrrw_pkg::WIN_BASE + 16'(N_ENTRIES));
	endfunction

	function automatic logic [5:0] win_idx(input logic [15:0] a);
		logic [15:0] d;
		d = a - mbrrw_pkg::WIN_BASE;
		return d[5:0];
	endfunction

	// ----------------------------------------------------------------
	// access state machine
	// ----------------------------------------------------------------
	mbrrw_pkg::mbrrw_state_e state_q, state_d;
	mbrrw_pkg::mbrrw_acc_s   cur_q, cur_d, drv_d;
	logic [5:0]  nv_addr_d;
	logic        nv_req_d, sup_en_q, sup_en_d, reboot_d;
	logic        req_ready_d, rsp_valid_d, drv_valid_d;
	logic [15:0] rsp_rdata_d, tgt;
	logic        mem_wr, mem_rd, taken;

	mbrrw_remap_mem #(
		.DEPTH (N_ENTRIES),
		.WIDTH (16),
		.AW    (6)
	) u_table (
		.clk       (clk),
		.resetn    (resetn),
		.ce        (ce),
		.wr_en     (mem_wr),
		.wr_idx    (nv_addr_q),
		.wr_data   (nv_data),
		.rd_en     (mem_rd),
		.rd_idx    (win_idx(req.addr)),
		.rd_data_q (tgt)
	);

	assign taken  = (state_q == mbrrw_pkg::ST_IDLE) && req_valid && req_ready_q;
	assign mem_rd = taken && in_window(req.addr);
	assign mem_wr = (state_q == mbrrw_pkg::ST_BOOT) && nv_valid &&
		(nv_addr_q < 6'(N_ENTRIES));

	// next values of the access path
	always_comb begin
		state_d     = state_q;
		cur_d       = cur_q;
		drv_d       = drv_q;
		nv_addr_d   = nv_addr_q;
		nv_req_d    = nv_req_q;
		sup_en_d    = sup_en_q;
		reboot_d    = reboot_req_q | commit;
		rsp_valid_d = 1'b0;
		rsp_rdata_d = rsp_rdata_q;
		case (state_q)
			mbrrw_pkg::ST_BOOT: begin
				// table records first, then the timer enable record
				nv_req_d = 1'b1;
				if (nv_valid) begin
					if (nv_addr_q == mbrrw_pkg::BOOT_SUP_EN) begin
						sup_en_d = nv_data[0];
						nv_req_d = 1'b0;
						state_d  = mbrrw_pkg::ST_IDLE;
					end else if (nv_addr_q == 6'(N_ENTRIES) - 6'h01) begin
						nv_addr_d = mbrrw_pkg::BOOT_SUP_EN;
					end else begin
						nv_addr_d = nv_addr_q + 6'h01;
					end
				end
			end
			mbrrw_pkg::ST_IDLE: begin
				if (taken) begin
					cur_d = req;
					if (in_window(req.addr)) begin
						state_d = mbrrw_pkg::ST_LOOK;
					end else begin
						drv_d   = req; // original address stays reachable
						state_d = mbrrw_pkg::ST_DRIVE;
					end
				end
			end
			mbrrw_pkg::ST_LOOK: begin
				if (tgt == mbrrw_pkg::NULL_TARGET) begin
					// null entry: no drive access at all
					rsp_valid_d = 1'b1;
					rsp_rdata_d = mbrrw_pkg::NULL_RDATA;
					state_d     = mbrrw_pkg::ST_IDLE;
				end else begin
					drv_d   = '{write: cur_q.write, addr: tgt, wdata: cur_q.wdata};
					state_d = mbrrw_pkg::ST_DRIVE;
				end
			end
			mbrrw_pkg::ST_DRIVE: begin
				// read answer comes from the drive each time, never from a copy; a write answers 0
				if (drv_done) begin
					rsp_valid_d = 1'b1;
					rsp_rdata_d = cur_q.write ? 16'h0000 : drv_rdata;
					state_d     = mbrrw_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = mbrrw_pkg::ST_BOOT;
			end
		endcase
		req_ready_d = (state_d == mbrrw_pkg::ST_IDLE);
		drv_valid_d = (state_d == mbrrw_pkg::ST_DRIVE);
	end

	// registers of the access path
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_q      <= mbrrw_pkg::ST_BOOT;
			cur_q        <= '0;
			drv_q        <= '0;
			nv_addr_q    <= 6'h00;
			nv_req_q     <= 1'b0;
			sup_en_q     <= 1'b0;
			reboot_req_q <= 1'b0;
			req_ready_q  <= 1'b0;
			rsp_valid_q  <= 1'b0;
			rsp_rdata_q  <= 16'h0000;
			drv_valid_q  <= 1'b0;
		end else if (ce) begin
			state_q      <= state_d;
			cur_q        <= cur_d;
			drv_q        <= drv_d;
			nv_addr_q    <= nv_addr_d;
			nv_req_q     <= nv_req_d;
			sup_en_q     <= sup_en_d;
			reboot_req_q <= reboot_d;
			req_ready_q  <= req_ready_d;
			rsp_valid_q  <= rsp_valid_d;
			rsp_rdata_q  <= rsp_rdata_d;
			drv_valid_q  <= drv_valid_d;
		end
	end

	// ----------------------------------------------------------------
	// connection timers
	// ----------------------------------------------------------------
	logic [31:0] sup_cnt_q, sup_cnt_d, conn_cnt_q, conn_cnt_d;
	logic        sup_armed_q, sup_armed_d, sup_to_d;
	logic        conn_act_q, conn_act_d, conn_to_d;

	// supervisory gap counts only after a first connection was seen, so a
	// freshly booted card with no client yet does not report a fault
	always_comb begin
		sup_cnt_d   = sup_cnt_q;
		sup_armed_d = sup_armed_q;
		sup_to_d    = sup_timeout_q;
		if (conn_open) begin
			sup_cnt_d   = 32'h0000_0000;
			sup_armed_d = sup_en_q;
			sup_to_d    = 1'b0;
		end else if (sup_en_q && sup_armed_q && !sup_timeout_q) begin
			if (sup_cnt_q >= SUP_CYCLES - 1) begin
				sup_to_d = 1'b1;
			end else begin
				sup_cnt_d = sup_cnt_q + 32'h0000_0001;
			end
		end
	end

	// per-connection idle timer, restarted by every accepted access
	always_comb begin
		conn_cnt_d = conn_cnt_q;
		conn_act_d = conn_act_q;
		conn_to_d  = conn_timeout_q;
		if (conn_open || taken) begin
			conn_cnt_d = 32'h0000_0000;
			conn_act_d = 1'b1;
			conn_to_d  = 1'b0;
		end else if (conn_close) begin
			conn_act_d = 1'b0;
			conn_to_d  = 1'b0;
		end else if (conn_act_q && !conn_timeout_q) begin
			if (conn_cnt_q >= CONN_CYCLES - 1) begin
				conn_to_d = 1'b1;
			end else begin
				conn_cnt_d = conn_cnt_q + 32'h0000_0001;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sup_cnt_q      <= 32'h0000_0000;
			sup_armed_q    <= 1'b0;
			sup_timeout_q  <= 1'b0;
			conn_cnt_q     <= 32'h0000_0000;
			conn_act_q     <= 1'b0;
			conn_timeout_q <= 1'b0;
		end else if (ce) begin
			sup_cnt_q      <= sup_cnt_d;
			sup_armed_q    <= sup_armed_d;
			sup_timeout_q  <= sup_to_d;
			conn_cnt_q     <= conn_cnt_d;
			conn_act_q     <= conn_act_d;
			conn_timeout_q <= conn_to_d;
		end
	end

endmodule

`default_nettype wire

// ==== test/mbrrw_checker.sv ====
// mbrrw_checker: concurrent checks on the remap window ports
`timescale 1ns/1ps
`default_nettype none
module mbrrw_checker #(
	parameter int unsigned SUP_CYCLES = 20
) (
	// clock, reset, boot load
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire logic                  nv_req_q,
	input wire logic [5:0]            nv_addr_q,
	input wire logic                  nv_valid,
	input wire logic                  commit,
	input wire logic                  reboot_req_q,
	// client and drive sides
	input wire logic                  req_valid,
	input wire mbrrw_pkg::mbrrw_acc_s req,
	input wire logic                  req_ready_q,
	input wire logic                  rsp_valid_q,
	input wire logic [15:0]           rsp_rdata_q,
	input wire logic                  drv_valid_q,
	input wire mbrrw_pkg::mbrrw_acc_s drv_q,
	input wire logic                  drv_done,
	input wire logic [15:0]           drv_rdata,
	// connection events and timeouts
	input wire logic                  conn_open,
	input wire logic                  conn_close,
	input wire logic                  sup_timeout_q,
	input wire logic                  conn_timeout_q
);
	// ----------------------------------------------------------------
	// helper logic
	// ----------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic        take;
	logic        in_win;
	logic        booted_q;
	logic [31:0] gap_q;
	assign take   = req_valid && req_ready_q;
	assign in_win = req.addr >= 16'h1389 && req.addr < 16'h13BB;
	// gap since the last open; 32 bits cannot wrap within a run
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			gap_q    <= 32'h0;
			booted_q <= 1'b0;
		end else begin
			gap_q    <= conn_open ? 32'h0 : gap_q + 32'h1;
			booted_q <= booted_q | (nv_req_q && nv_valid && nv_addr_q == 6'h32);
		end
	end
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	sequence s_drv_end; drv_valid_q && drv_done; endsequence
	sequence s_answer; rsp_valid_q && req_ready_q && !drv_valid_q; endsequence
	property p_drv_rsp;
		s_drv_end |=> s_answer ##0 rsp_rdata_q == ($past(drv_q.write) ? 16'h0000 : $past(drv_rdata));
	endproperty
	property p_drv_hold; drv_valid_q && !drv_done |=> drv_valid_q && $stable(drv_q); endproperty
	property p_pass; take && !in_win |=> drv_valid_q && drv_q == $past(req); endproperty
	property p_null;
		take && in_win |=> !rsp_valid_q && !drv_valid_q
			##1 (drv_valid_q ? drv_q.addr != 16'h0000 : rsp_valid_q && rsp_rdata_q == 16'h0000);
	endproperty
	property p_win_data;
		take && in_win ##2 drv_valid_q |-> drv_q.wdata == $past(req.wdata, 2)
			&& drv_q.write == $past(req.write, 2);
	endproperty
	property p_reboot; commit || reboot_req_q |=> reboot_req_q; endproperty
	property p_boot_end; nv_req_q && nv_valid && nv_addr_q == 6'h32 |=> !nv_req_q && req_ready_q; endproperty
	property p_boot_once; booted_q |-> !nv_req_q; endproperty
	property p_sup_rise; $rose(sup_timeout_q) |-> gap_q == SUP_CYCLES; endproperty
	property p_sup_clr; conn_open |=> !sup_timeout_q; endproperty
	property p_conn_clr; conn_close || take |=> !conn_timeout_q; endproperty
	a_drv_rsp:   assert property (p_drv_rsp) else $error("drive answer not returned");
	a_drv_hold:  assert property (p_drv_hold) else $error("drive access dropped");
	a_pass:      assert property (p_pass) else $error("plain address altered");
	a_null:      assert property (p_null) else $error("null entry misrouted");
	a_win_data:  assert property (p_win_data) else $error("window access data lost");
	a_reboot:    assert property (p_reboot) else $error("reboot request missing");
	a_boot_end:  assert property (p_boot_end) else $error("boot load did not end");
	a_boot_once: assert property (p_boot_once) else $error("config reloaded");
	a_sup_rise:  assert property (p_sup_rise) else $error("supervisory timeout early or late");
	a_sup_clr:   assert property (p_sup_clr) else $error("supervisory timeout kept");
	a_conn_clr:  assert property (p_conn_clr) else $error("connection timeout kept");
endmodule
`default_nettype wire

// ==== test/mbrrw_drive_model.sv ====
// mbrrw_drive_model: behavioural drive register space on the far side
`timescale 1ns/1ps
`default_nettype none
module mbrrw_drive_model (
	// clock and access port
	input  wire logic                  clk,
	input  wire logic                  drv_valid_q,
	input  wire mbrrw_pkg::mbrrw_acc_s drv_q,
	output logic                       drv_done,
	output logic      [15:0]           drv_rdata
);
	logic [15:0] mem [logic [15:0]];
	int          cnt = 0;
	int          lim = 1;
	initial begin
		drv_done  = 1'b0;
		drv_rdata = 16'hFFFF;
	end
	// varying wait; read data scrambled outside the done cycle so stale use shows
	always @(posedge clk) begin
		#1;
		if (drv_done) begin
			drv_done  = 1'b0;
			drv_rdata = ~drv_rdata;
		end else if (drv_valid_q) begin
			cnt++;
			if (cnt > lim) begin
				if (drv_q.write) mem[drv_q.addr] = drv_q.wdata;
				drv_rdata = mem.exists(drv_q.addr) ? mem[drv_q.addr] : drv_q.addr ^ 16'h5A5A;
				drv_done  = 1'b1;
				cnt       = 0;
				lim       = $urandom % 3;
			end
		end
	end
endmodule
`default_nettype wire

// ==== test/tb.sv ====
// tb: self-checking bench for the register remap window
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----------------------------------------------------------------
	// signals and instances
	// ----------------------------------------------------------------
	localparam int unsigned SC = 20; // shortened timer counts
	logic                  clk = 0, resetn = 0, ce = 1, nv_valid = 0, commit = 0, req_valid = 0;
	logic                  conn_open = 0, conn_close = 0, nv_req_q, req_ready_q, rsp_valid_q;
	logic                  drv_valid_q, drv_done, reboot_req_q, sup_timeout_q, conn_timeout_q;
	logic [5:0]            nv_addr_q;
	logic [15:0]           nv_data = 0, rsp_rdata_q, drv_rdata;
	mbrrw_pkg::mbrrw_acc_s req = '0, drv_q;
	logic [15:0]           sh [logic [15:0]]; // shadow of drive registers
	logic [15:0]           tgt [50];
	logic [15:0]           expq [$];
	int                    n_errors = 0, samples_checked = 0, cyc = 0;
	always #12.5 clk = ~clk;
	mbrrw_remap_window #(.SUP_CYCLES(SC), .CONN_CYCLES(SC)) i_mbrrw_remap_window (.clk, .resetn,
		.ce, .nv_req_q, .nv_addr_q, .nv_valid, .nv_data, .commit, .reboot_req_q, .req_valid, .req,
		.req_ready_q, .rsp_valid_q, .rsp_rdata_q, .drv_valid_q, .drv_q, .drv_done, .drv_rdata,
		.conn_open, .conn_close, .sup_timeout_q, .conn_timeout_q);
	mbrrw_drive_model i_mbrrw_drive_model (.clk, .drv_valid_q, .drv_q, .drv_done, .drv_rdata);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	function automatic logic [15:0] rd(input logic [15:0] a);
		return sh.exists(a) ? sh[a] : a ^ 16'h5A5A;
	endfunction
	task automatic cmp(input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value at %0t: expected %h got %h", $time, e, g);
		end
	endtask
	task automatic complete_run;
		if (n_errors == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// one word access; expectation is noted before the request goes out
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d);
		logic [15:0] t;
		t = a;
		if (a >= 16'h1389 && a < 16'h13BB) t = tgt[a - 16'h1389];
		expq.push_back((w || t == 16'h0000) ? 16'h0000 : rd(t));
		if (w && t != 16'h0000) sh[t] = d;
		while (!req_ready_q) tick(1);
		req_valid = 1;
		req = '{w, a, d};
		tick(1);
		req_valid = 0;
	endtask
	task automatic boot(input logic [15:0] en);
		resetn = 0;
		tick(2);
		resetn = 1;
		while (!nv_req_q) tick(1);
		while (nv_req_q) begin
			nv_valid = 1;
			nv_data = (nv_addr_q == 6'h32) ? en : tgt[nv_addr_q];
			tick(1);
		end
		nv_valid = 0;
	endtask
	// ----------------------------------------------------------------
	// checking and sequence
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		#1;
		cyc++;
		if (rsp_valid_q && expq.size() == 0) begin
			n_errors++;
			$display("wrong value at %0t: expected none got %h", $time, rsp_rdata_q);
		end else if (rsp_valid_q) cmp(expq.pop_front(), rsp_rdata_q);
		if (cyc == 5000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(32'h44C2));
		for (int k = 0; k < 50; k++) tgt[k] = (k % 7 == 6) ? 16'h0800 + 16'($urandom % 200) : 16'h0000;
		tgt[0] = 16'h0706;
		tgt[1] = 16'h0707;
		tgt[2] = 16'h080A;
		tgt[3] = 16'h0816;
		tgt[4] = 16'h080F;
		boot(16'h0001);
		for (int k = 0; k < 3; k++) acc(0, 16'h138B + 16'(k), 0);
		for (int k = 0; k < 2; k++) acc(1, 16'h1389 + 16'(k), 16'($urandom));
		acc(0, 16'h0706, 0);
		acc(1, 16'h080A, 16'($urandom));
		acc(0, 16'h138B, 0);
		for (int k = 0; k < 52; k++) acc(1, 16'h1388 + 16'(k), 16'($urandom));
		for (int k = 0; k < 52; k++) acc(0, 16'h1388 + 16'(k), 0);
		conn_open = 1;
		tick(1);
		conn_open = 0;
		tick(SC - 2);
		cmp(16'h0000, 16'(sup_timeout_q));
		tick(3);
		cmp(16'h0001, 16'(sup_timeout_q));
		cmp(16'h0001, 16'(conn_timeout_q));
		acc(0, 16'h1389, 0);
		tick(1);
		cmp(16'h0000, 16'(conn_timeout_q));
		cmp(16'h0001, 16'(sup_timeout_q));
		conn_open = 1;
		tick(1);
		conn_open = 0;
		tick(1);
		cmp(16'h0000, 16'(sup_timeout_q));
		// a closed connection must not run its idle timer
		conn_close = 1;
		tick(1);
		conn_close = 0;
		tick(SC + 2);
		cmp(16'h0000, 16'(conn_timeout_q));
		cmp(16'h0001, 16'(sup_timeout_q));
		commit = 1;
		tick(1);
		commit = 0;
		tick(1);
		cmp(16'h0001, 16'(reboot_req_q));
		tgt[2] = 16'h0000;
		boot(16'h0000); // new settings only after the restart
		cmp(16'h0000, 16'(reboot_req_q));
		acc(0, 16'h138B, 0);
		// timer now disabled: a long gap after an open must stay quiet
		conn_open = 1;
		tick(1);
		conn_open = 0;
		tick(SC + 2);
		cmp(16'h0000, 16'(sup_timeout_q));
		tick(10);
		cmp(16'h0000, 16'(expq.size()));
		complete_run();
	end
endmodule
bind mbrrw_remap_window mbrrw_checker #(.SUP_CYCLES(SUP_CYCLES)) i_mbrrw_checker (.clk, .resetn,
	.nv_req_q, .nv_addr_q, .nv_valid, .commit, .reboot_req_q, .req_valid, .req, .req_ready_q,
	.rsp_valid_q, .rsp_rdata_q, .drv_valid_q, .drv_q, .drv_done, .drv_rdata, .conn_open,
	.conn_close, .sup_timeout_q, .conn_timeout_q);
`default_nettype wire
